//--- design/cdbpa_pkg.sv
package cdbpa_pkg;
  // Channel count and modulator word width
  localparam int NCH = 6;
  localparam int DW = 4;
  // Phase, cutoff and ratio field widths
  localparam int PHW = 10;
  localparam int SELW = 4;
  localparam int OSRW = 3;
  // Window counter width covers the largest ratio
  localparam int CNTW = 14;
  // Fraction bits of the high-pass running estimate
  localparam int FRAC = 16;
  // Master clock and modulator tick divider
  localparam int FCLK_MHZ = 100;
  localparam int MOD_DIV = 2;
  // Smallest ratio, applied at ratio code zero
  localparam logic [14:0] OSR_MIN = 15'h0080;
  // Phase limit base at code zero, fixed cap and the code where it applies
  localparam logic [10:0] PH_BASE = 11'h040;
  localparam logic [10:0] PH_CAP = 11'h200;
  localparam logic [2:0] PH_CAP_SEL = 3'h3;
  // Cutoff select code that bypasses the high-pass stage
  localparam logic [3:0] HP_BYPASS = 4'h0;
  // Input selector codes
  localparam logic [1:0] MUX_EXT = 2'h0;
  localparam logic [1:0] MUX_POS = 2'h1;
  localparam logic [1:0] MUX_NEG = 2'h2;
  localparam logic [1:0] MUX_ZERO = 2'h3;
  // Internal test level in modulator word units
  localparam logic [3:0] TEST_LEVEL = 4'h3;
endpackage

//--- design/cdbpa_buf.sv
`timescale 1ns/10ps
module cdbpa_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [W-1:0] tail_ff;
  logic tail_v_ff;
  wire push = in_valid_i && !tail_v_ff;
  wire pop = out_valid_o && out_ready_i;
  wire head_free = pop || !out_valid_o;

  initial begin
    if (W < 1) $error("cdbpa_buf: width must be positive");
  end

  // Head entry refills from the tail first, then from the input
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      tail_v_ff <= 1'b0;
      tail_ff <= '0;
    end else if (head_free) begin
      out_valid_o <= tail_v_ff || push;
      out_data_o <= tail_v_ff ? tail_ff : in_data_i;
      tail_v_ff <= 1'b0;
    end else if (push) begin
      tail_ff <= in_data_i;
      tail_v_ff <= 1'b1;
    end
  end

  // Ready drops only once both entries hold words
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) in_ready_o <= 1'b0;
    else in_ready_o <= !(out_valid_o && !pop && (tail_v_ff || push)) &&
                       !(tail_v_ff && !head_free);
  end

  // A stalled word holds still until taken
  a_buf_hold_word: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("buffered word changed while stalled");
endmodule // cdbpa_buf

//--- design/cdbpa_top.sv
`timescale 1ns/10ps
module cdbpa_top #(
  parameter int NCH = cdbpa_pkg::NCH,
  parameter int DW = cdbpa_pkg::DW
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Modulator words, one DW slice per channel, taken on each modulator tick
  input wire logic [NCH*DW-1:0] mod_data_i,
  // Shared configuration
  input wire logic [cdbpa_pkg::SELW-1:0] highpass_cutoff_sel_i,
  input wire logic [cdbpa_pkg::OSRW-1:0] decimation_ratio_i,
  // Per-channel configuration
  input wire logic [NCH-1:0] ch_highpass_off_i,
  input wire logic [NCH*2-1:0] ch_input_select_i,
  input wire logic [NCH*cdbpa_pkg::PHW-1:0] ch_sample_delay_i,
  // Result stream
  output logic sample_valid_o,
  output logic [$clog2(NCH)+DW+cdbpa_pkg::CNTW:0] sample_data_o,
  input wire logic sample_ready_i,
  // Status
  output logic conversion_ready_flag_o,
  output logic overrun_o
);
  localparam int ACCW = DW + cdbpa_pkg::CNTW;
  localparam int OW = ACCW + 1;
  localparam int CHW = $clog2(NCH);
  localparam int EW = OW + cdbpa_pkg::FRAC;
  localparam int PHW = cdbpa_pkg::PHW;
  localparam int CNTW = cdbpa_pkg::CNTW;

  initial begin
    if (NCH < 2 || NCH > 16) $error("cdbpa_top: NCH must be 2 to 16");
    if (DW < 2 || DW > 8) $error("cdbpa_top: DW must be 2 to 8");
  end

  // Saturate the phase to the range the current ratio allows
  function automatic logic [PHW-1:0] clip_phase(input logic [PHW-1:0] ph,
                                                input logic [2:0] r);
    logic signed [10:0] lim;
    logic signed [10:0] v;
    lim = (r >= cdbpa_pkg::PH_CAP_SEL) ? $signed(cdbpa_pkg::PH_CAP) :
          $signed(cdbpa_pkg::PH_BASE << r);
    v = $signed({ph[PHW-1], ph});
    if (v < -lim) v = -lim;
    else if (v > lim - 11'sh001) v = lim - 11'sh001;
    return v[PHW-1:0];
  endfunction

  // Lowest set bit of a pending vector
  function automatic logic [CHW-1:0] first_set(input logic [NCH-1:0] v);
    logic [CHW-1:0] idx;
    idx = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) idx = CHW'(i);
    end
    return idx;
  endfunction

  // Modulator tick divider
  logic [3:0] div_ff;
  wire tick = (div_ff == 4'(cdbpa_pkg::MOD_DIV - 1));
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) div_ff <= 4'h0;
    else div_ff <= tick ? 4'h0 : div_ff + 4'h1;
  end

  // Window length from the ratio code
  wire [14:0] osr_w = cdbpa_pkg::OSR_MIN << decimation_ratio_i;
  wire [CNTW-1:0] osr_m1 = CNTW'(osr_w - 15'h0001);

  // Reference window counter, zero phase ends windows at osr_m1
  logic [CNTW-1:0] mcnt_ff;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) mcnt_ff <= '0;
    else if (tick) mcnt_ff <= (mcnt_ff >= osr_m1) ? '0 : mcnt_ff + 14'h1;
  end

  // Per-channel input select, phase clip and window end index
  logic signed [DW-1:0] smp [NCH];
  logic [PHW-1:0] ph_clip [NCH];
  logic [NCH-1:0] emit;
  logic [NCH-1:0] ph_zero;
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire [1:0] msel = ch_input_select_i[2*c +: 2];
    wire [PHW-1:0] ph_raw = ch_sample_delay_i[PHW*c +: PHW];
    wire [CNTW-1:0] ph_ext = {{(CNTW-PHW){ph_clip[c][PHW-1]}}, ph_clip[c]};
    wire [CNTW-1:0] end_idx = CNTW'(osr_m1 + ph_ext) & osr_m1;
    assign smp[c] = (msel == cdbpa_pkg::MUX_POS) ?
                      $signed(DW'(cdbpa_pkg::TEST_LEVEL)) :
                    (msel == cdbpa_pkg::MUX_NEG) ?
                      -$signed(DW'(cdbpa_pkg::TEST_LEVEL)) :
                    (msel == cdbpa_pkg::MUX_ZERO) ? '0 :
                    $signed(mod_data_i[DW*c +: DW]);
    assign ph_clip[c] = clip_phase(ph_raw, decimation_ratio_i);
    assign emit[c] = tick && (mcnt_ff == end_idx);
    assign ph_zero[c] = (ph_raw == '0);
  end

  // Window accumulators and captured results
  logic signed [ACCW-1:0] acc_ff [NCH];
  logic signed [ACCW-1:0] res_ff [NCH];
  logic [NCH-1:0] pend_ff;
  logic [NCH-1:0] fresh_ff;
  logic buf_ready;
  wire take = (pend_ff != '0) && buf_ready;
  wire [CHW-1:0] dch = first_set(pend_ff);
  wire [NCH-1:0] drain = take ? (NCH'(1) << dch) : '0;
  wire [NCH-1:0] lost = emit & pend_ff & ~drain;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < NCH; c++) acc_ff[c] <= '0;
      for (int c = 0; c < NCH; c++) res_ff[c] <= '0;
    end else if (tick) begin
      for (int c = 0; c < NCH; c++) begin
        acc_ff[c] <= emit[c] ? '0 : acc_ff[c] + ACCW'(smp[c]);
        if (emit[c]) res_ff[c] <= acc_ff[c] + ACCW'(smp[c]);
      end
    end
  end

  // New results win over the drain of the same channel
  wire [NCH-1:0] nxt_fresh = (fresh_ff | emit);
  wire all_fresh = &nxt_fresh;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_ff <= '0;
      fresh_ff <= '0;
      conversion_ready_flag_o <= 1'b0;
      overrun_o <= 1'b0;
    end else begin
      pend_ff <= (pend_ff & ~drain) | emit;
      fresh_ff <= all_fresh ? '0 : nxt_fresh;
      conversion_ready_flag_o <= all_fresh;
      overrun_o <= (lost != '0);
    end
  end

  // High-pass stage applied as each result is drained
  logic signed [EW-1:0] est_ff [NCH];
  wire hp_on = (highpass_cutoff_sel_i != cdbpa_pkg::HP_BYPASS) &&
               !ch_highpass_off_i[dch];
  wire [4:0] hp_shift = 5'(highpass_cutoff_sel_i) + 5'h01;
  wire signed [OW-1:0] x_in = OW'(res_ff[dch]);
  wire signed [OW-1:0] est_int = est_ff[dch][EW-1:cdbpa_pkg::FRAC];
  wire signed [OW-1:0] hp_err = x_in - est_int;
  wire signed [EW-1:0] est_step =
    (EW'(hp_err) <<< cdbpa_pkg::FRAC) >>> hp_shift;
  wire signed [OW-1:0] y_out = hp_on ? hp_err : x_in;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < NCH; c++) est_ff[c] <= '0;
    end else if (take && hp_on) begin
      est_ff[dch] <= est_ff[dch] + est_step;
    end
  end

  // Two-entry buffer toward the reader
  cdbpa_buf #(.W(CHW + OW)) u_buf (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .in_valid_i(take),
    .in_data_i({dch, y_out}),
    .in_ready_o(buf_ready),
    .out_valid_o(sample_valid_o),
    .out_data_o(sample_data_o),
    .out_ready_i(sample_ready_i)
  );

  // Helper window counter for channel zero
  logic [CNTW:0] win0_ff;
  logic win0_seen_ff;
  logic [2:0] ratio_q_ff;
  logic [PHW-1:0] ph0_q_ff;
  // A ratio or phase change restarts the full-window qualification
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      win0_ff <= '0;
      win0_seen_ff <= 1'b0;
      ratio_q_ff <= 3'h0;
      ph0_q_ff <= '0;
    end else if (tick) begin
      ratio_q_ff <= decimation_ratio_i;
      ph0_q_ff <= ph_clip[0];
      win0_ff <= emit[0] ? '0 : win0_ff + 15'h0001;
      win0_seen_ff <= (ratio_q_ff == decimation_ratio_i) &&
                      (ph0_q_ff == ph_clip[0]) &&
                      (emit[0] || win0_seen_ff);
    end
  end

  a_bypass_zero_sel: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    take && highpass_cutoff_sel_i == 4'h0 |-> y_out == x_in)
    else $error("high-pass active with cutoff code zero");

  a_chan_off_pass: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    take && ch_highpass_off_i[dch] |-> y_out == x_in ##1
      est_ff[$past(dch)] == $past(est_ff[dch]))
    else $error("high-pass active on a disabled channel");

  a_hp_step_size: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    take && hp_on && highpass_cutoff_sel_i == 4'h1
    |=> est_ff[$past(dch)] == $past(est_ff[dch]) + ($past(hp_err) <<< 14))
    else $error("estimate step not a quarter of the error at code one");

  a_test_level: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    ch_input_select_i[1:0] == 2'h2 |-> smp[0] == -4'sd3)
    else $error("negative test level not routed");

  a_phase_limit: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    decimation_ratio_i == 3'h0 |->
      $signed(ph_clip[0]) >= -10'sd64 && $signed(ph_clip[0]) <= 10'sd63)
    else $error("phase outside range at ratio 128");

  a_phase_cap_wide: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    decimation_ratio_i >= 3'h3 |-> ph_clip[0] == ch_sample_delay_i[9:0])
    else $error("phase changed at a wide ratio");

  a_window_length: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    emit[0] && win0_seen_ff && ratio_q_ff == decimation_ratio_i &&
    ph0_q_ff == ph_clip[0]
    |-> win0_ff == {1'b0, osr_m1})
    else $error("window length differs from ratio");

  a_zero_align: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    (&ph_zero) |-> emit == '0 || (&emit))
    else $error("zero-phase windows not aligned");

  a_ready_cause: assert property (@(posedge mclk_i)
    disable iff (!resetn_i)
    conversion_ready_flag_o |->
      $past(emit != '0) && !$past(conversion_ready_flag_o))
    else $error("ready flag without a window end");
endmodule // cdbpa_top

//--- tb/cdbpa_host.sv
`timescale 1ns/10ps
// Host reader model: takes result words and stalls on command
module cdbpa_host (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Stall controls
  input wire logic slow_i,
  input wire logic hold_i,
  input wire logic rnd_i,
  // Result stream
  input wire logic sample_valid_i,
  input wire logic [21:0] sample_data_i,
  output logic sample_ready_o
);
  int idx [8];
  initial sample_ready_o = 1'b0;
  // Ready moves only at the falling edge
  always @(negedge mclk_i) begin
    sample_ready_o <= resetn_i & ~hold_i & (~slow_i | rnd_i);
  end
  // Per-channel word index, advanced on each word taken
  always @(posedge mclk_i) begin
    if (sample_valid_i && sample_ready_o) begin
      idx[sample_data_i[21:19]]++;
    end
  end
endmodule // cdbpa_host

//--- tb/cdbpa_top_tb.sv
`timescale 1ns/10ps
module cdbpa_top_tb;
  typedef struct {int ch; logic [18:0] v;} cdbpa_note_t;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [23:0] mod_data = 24'h0;
  logic [3:0] cut = 4'h0;
  logic [2:0] ratio = 3'h0;
  logic [5:0] hp_off = 6'h0;
  logic [11:0] sel = 12'h0;
  logic [59:0] dly = 60'h0;
  logic slow = 1'b1;
  logic hold = 1'b0;
  logic rnd = 1'b0;
  logic valid, ready, flag, ovr;
  logic [21:0] data;
  logic [31:0] seed = 32'h5a76;
  logic [31:0] rs = 32'h5a76;
  int num_errors = 0;
  int tests_run = 0;
  int n_ovr = 0;
  cdbpa_note_t q[$];
  logic [18:0] last_v [6];
  longint last_t [6];

  // Master clock, 10 ns period
  always #5 mclk_i = ~mclk_i;

  cdbpa_top i_cdbpa_top (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .mod_data_i(mod_data), .highpass_cutoff_sel_i(cut),
    .decimation_ratio_i(ratio), .ch_highpass_off_i(hp_off),
    .ch_input_select_i(sel), .ch_sample_delay_i(dly),
    .sample_valid_o(valid), .sample_data_o(data),
    .sample_ready_i(ready), .conversion_ready_flag_o(flag),
    .overrun_o(ovr));
  cdbpa_host i_cdbpa_host (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .slow_i(slow), .hold_i(hold), .rnd_i(rnd), .sample_valid_i(valid),
    .sample_data_i(data), .sample_ready_o(ready));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wait_flag;
    int k;
    k = 0;
    do begin
      @(negedge mclk_i);
      k++;
    end while (flag !== 1'b1 && k < 40000);
    if (k >= 40000) num_errors++;
  endtask

  // Random stall pattern for the reader
  always @(negedge mclk_i) begin
    rs = lfsr_next(rs);
    rnd <= rs[0];
  end

  // Watcher: note each word, compare it with the oldest note when their channels match
  always @(posedge mclk_i) begin
    if (valid === 1'b1 && ready === 1'b1) begin
      last_v[data[21:19]] = data[18:0];
      last_t[data[21:19]] = $time;
      if (q.size() > 0 && q[0].ch == data[21:19]) begin
        check({13'h0, data[18:0]}, {13'h0, q[0].v});
        void'(q.pop_front());
      end
    end
    if (ovr === 1'b1) n_ovr++;
  end

  // Random inputs and selectors, bypassed filter, one full round noted
  task automatic data_round(input logic [2:0] code);
    logic [18:0] ex [6];
    logic [18:0] d;
    logic [18:0] lv;
    lv = 19'(cdbpa_pkg::TEST_LEVEL) << (7 + code);
    ratio = code;
    cut = 4'h0;
    dly = 60'h0;
    slow = 1'b1;
    for (int k = 0; k < 6; k++) begin
      seed = lfsr_next(seed);
      mod_data[4*k +: 4] = seed[3:0];
      sel[2*k +: 2] = seed[5:4];
      hp_off[k] = seed[6];
      d = {{15{seed[3]}}, seed[3:0]};
      case (seed[5:4])
        cdbpa_pkg::MUX_EXT: ex[k] = d << (7 + code);
        cdbpa_pkg::MUX_POS: ex[k] = lv;
        cdbpa_pkg::MUX_NEG: ex[k] = -lv;
        default: ex[k] = 19'h0;
      endcase
    end
    repeat (2) wait_flag;
    for (int k = 0; k < 6; k++) q.push_back('{k, ex[k]});
    wait_flag;
  endtask

  // Channel 0 shifted, arrival gap to channel 1 measured
  task automatic phase_case(input logic [2:0] code, input logic [9:0] ph);
    logic signed [11:0] p, lim;
    longint per, dt, ex;
    ratio = code;
    slow = 1'b0;
    dly = {50'h0, ph};
    lim = (code >= 3) ? 12'sh200 : 12'sh040 <<< code;
    p = $signed(ph);
    if (p > lim - 1) p = lim - 1;
    if (p < -lim) p = -lim;
    per = 256 << code;
    repeat (4) wait_flag;
    repeat (10) @(negedge mclk_i);
    dt = ((last_t[0] - last_t[1]) / 10 % per + per) % per;
    ex = (2 * p % per + per) % per;
    check(32'(dt), 32'(ex));
  endtask

  // Filtered channel 0 decays by its coefficient, channel 1 stays raw
  task automatic hp_case(input logic [3:0] k);
    logic signed [20:0] a, b, e;
    cut = k;
    ratio = 3'h0;
    hp_off = 6'h02;
    dly = 60'h0;
    sel = {8'h0, cdbpa_pkg::MUX_POS,
           k[0] ? cdbpa_pkg::MUX_POS : cdbpa_pkg::MUX_NEG};
    repeat (2) wait_flag;
    repeat (10) @(negedge mclk_i);
    a = $signed(last_v[0]);
    q.push_back('{1, 19'(cdbpa_pkg::TEST_LEVEL) << 7});
    wait_flag;
    repeat (10) @(negedge mclk_i);
    b = $signed(last_v[0]);
    e = a - (a >>> (k + 1));
    check({31'h0, (b - e <= 2) && (e - b <= 2)}, 32'h1);
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    resetn_i = 1'b1;
    for (int c = 0; c < 3; c++) data_round(3'(c));
    check(32'(n_ovr), 32'h0);
    phase_case(3'h0, 10'h064);
    phase_case(3'h0, 10'h39c);
    phase_case(3'h1, 10'h07f);
    phase_case(3'h2, 10'h2d4);
    phase_case(3'h3, 10'h1ff);
    phase_case(3'h4, 10'h200);
    for (int k = 1; k < 16; k++) hp_case(4'(k));
    // Reader stalls across rounds: buffer fills, a result is overwritten
    hold = 1'b1;
    repeat (700) @(negedge mclk_i);
    hold = 1'b0;
    check(32'(n_ovr > 0), 32'h1);
    data_round(3'h0);
    check(32'(q.size()), 32'h0);
    end_of_test;
  end

  // Watchdog over the whole run
  initial begin
    #1000000;
    num_errors++;
    end_of_test;
  end
endmodule // cdbpa_top_tb
